// ==== shared/asrc_consts.vh ====
// Purpose: Constants for the async SRAM port host controller
// Assumes: 50 MHz clock, 20 ns period
// Notes: Times in ns; cycle counts derived from them
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH
`define ASRC_CLK_PERIOD_NS 20
// Write cycle and pulse minima, slower grade
`define ASRC_T_WC_NS 85
`define ASRC_T_WP_NS 60
`define ASRC_T_DW_NS 35
// Write strobe to output high impedance, maximum
`define ASRC_T_WHZ_NS 25
// Read cycle time and access time
`define ASRC_T_RC_NS 85
`define ASRC_T_AA_NS 85
// Bus turnaround after output disable
`define ASRC_T_OHZ_NS 25
// Least times round up to whole cycles
`define ASRC_CYC_UP(t) (((t) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_WP_CYC `ASRC_CYC_UP(`ASRC_T_WP_NS)
`define ASRC_WHZ_CYC `ASRC_CYC_UP(`ASRC_T_WHZ_NS)
`define ASRC_AA_CYC `ASRC_CYC_UP(`ASRC_T_AA_NS)
`define ASRC_OHZ_CYC `ASRC_CYC_UP(`ASRC_T_OHZ_NS)
// Extra edges for the data pin chain to settle on a read
`define ASRC_SYNC_CYC 2
// Byte lane mask values
`define ASRC_LANE_LOW 2'h1
`define ASRC_LANE_HIGH 2'h2
`define ASRC_LANE_BOTH 2'h3
`endif

// ==== hw/asrc_host.v ====
// Purpose: Host controller driving an asynchronous SRAM port
// Assumes: Single 50 MHz clock; the SRAM keeps its own timing
// Notes: One request at a time; strobes come from flip-flops
`timescale 1ns/10ps
`include "asrc_consts.vh"
`default_nettype none
module asrc_host #(
   parameter AW = 18,
   parameter DW = 16
) (
   input wire clk,
   input wire reset_n,
   input wire req_valid,
   output wire req_ready,
   input wire req_write,
   input wire [AW-1:0] req_addr,
   input wire [DW-1:0] req_wdata,
   input wire [1:0] req_lanes,
   output reg rsp_valid,
   output reg [DW-1:0] rsp_rdata,
   output reg [AW-1:0] sram_addr,
   output reg sram_select_low_active_n,
   output reg sram_select_high_active,
   output reg write_strobe_n,
   output reg output_enable_n,
   output reg upper_byte_select_n,
   output reg lower_byte_select_n,
   output reg sram_width_select,
   input wire [DW-1:0] sram_data_in,
   output reg [DW-1:0] sram_data_out,
   output reg sram_data_oe
);
   localparam ST_IDLE = 3'd0;
   localparam ST_WSET = 3'd1;
   localparam ST_WPULSE = 3'd2;
   localparam ST_WEND = 3'd3;
   localparam ST_RD = 3'd4;
   localparam ST_TURN = 3'd5;
   // Cycle counts, cut to the counter width on purpose
   localparam integer WP_CYC_I = `ASRC_WP_CYC;
   localparam integer WHZ_CYC_I = `ASRC_WHZ_CYC;
   localparam integer AA_CYC_I = `ASRC_AA_CYC;
   localparam integer OHZ_CYC_I = `ASRC_OHZ_CYC;
   localparam integer SYNC_CYC_I = `ASRC_SYNC_CYC;
   localparam [3:0] WP_CYC = WP_CYC_I[3:0];
   localparam [3:0] WHZ_CYC = WHZ_CYC_I[3:0];
   localparam [3:0] AA_CYC = AA_CYC_I[3:0];
   localparam [3:0] OHZ_CYC = OHZ_CYC_I[3:0];
   localparam [3:0] SYNC_CYC = SYNC_CYC_I[3:0];
   // Read wait covers access time plus the pin chain
   localparam [3:0] RD_WAIT = AA_CYC + SYNC_CYC;

   reg [2:0] state_q;
   reg [3:0] cnt_q;
   reg [1:0] lanes_q;
   // Three-stage chain on the data pins
   reg [DW-1:0] pin_s1_q;
   reg [DW-1:0] pin_s2_q;
   reg [DW-1:0] pin_s3_q;
   // Lane request after the empty-mask fix
   wire [1:0] req_lanes_fixed;
   // High while the selected lanes agree in stages two and three
   wire pin_settled;

   // Lane request sanitised: an empty mask becomes a full word
   function [1:0] fix_lanes;
      input [1:0] l;
      begin
         fix_lanes = (l == 2'h0) ? `ASRC_LANE_BOTH : l;
      end
   endfunction

   // Counter step shared by every wait state
   function [3:0] dec_cnt;
      input [3:0] c;
      begin
         dec_cnt = c - 4'h1;
      end
   endfunction

   // Bit mask of the data lines that belong to the selected lanes
   function [DW-1:0] lane_mask;
      input [1:0] l;
      begin
         lane_mask = {{(DW/2){l[1]}}, {(DW/2){l[0]}}};
      end
   endfunction

   assign req_ready = (state_q == ST_IDLE);

   // Lane fix and agreement of the settled pin stages
   assign req_lanes_fixed = fix_lanes(req_lanes);
   assign pin_settled = (((pin_s2_q ^ pin_s3_q) & lane_mask(lanes_q))
      == {DW{1'b0}});

   // Data pins pass three flops before the read sample
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_q <= {DW{1'b0}};
         pin_s2_q <= {DW{1'b0}};
         pin_s3_q <= {DW{1'b0}};
      end else begin
         pin_s1_q <= sram_data_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // Pin sequencing for write and read cycles
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         lanes_q <= 2'h0;
         rsp_valid <= 1'b0;
         rsp_rdata <= {DW{1'b0}};
         sram_addr <= {AW{1'b0}};
         sram_select_low_active_n <= 1'b1;
         sram_select_high_active <= 1'b0;
         write_strobe_n <= 1'b1;
         output_enable_n <= 1'b1;
         upper_byte_select_n <= 1'b1;
         lower_byte_select_n <= 1'b1;
         sram_width_select <= 1'b1;
         sram_data_out <= {DW{1'b0}};
         sram_data_oe <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  sram_addr <= req_addr;
                  lanes_q <= req_lanes_fixed;
                  upper_byte_select_n <= ~req_lanes_fixed[1];
                  lower_byte_select_n <= ~req_lanes_fixed[0];
                  sram_width_select <= 1'b1;
                  sram_select_high_active <= 1'b1;
                  if (req_write) begin
                     output_enable_n <= 1'b1;
                     sram_data_out <= req_wdata;
                     state_q <= ST_WSET;
                  end else begin
                     sram_select_low_active_n <= 1'b0;
                     output_enable_n <= 1'b0;
                     cnt_q <= RD_WAIT;
                     state_q <= ST_RD;
                  end
               end
            end
            ST_WSET: begin
               // strobe falls with lanes already set
               sram_select_low_active_n <= 1'b0;
               write_strobe_n <= 1'b0;
               cnt_q <= WHZ_CYC;
               state_q <= ST_WPULSE;
            end
            ST_WPULSE: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= dec_cnt(cnt_q);
               end else if (!sram_data_oe) begin
                  sram_data_oe <= 1'b1;
                  cnt_q <= WP_CYC;
               end else begin
                  sram_select_low_active_n <= 1'b1;
                  write_strobe_n <= 1'b1;
                  state_q <= ST_WEND;
               end
            end
            ST_WEND: begin
               // Data held one cycle past strobe rise
               sram_data_oe <= 1'b0;
               sram_select_high_active <= 1'b0;
               upper_byte_select_n <= 1'b1;
               lower_byte_select_n <= 1'b1;
               state_q <= ST_IDLE;
            end
            ST_RD: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= dec_cnt(cnt_q);
               end else if (pin_settled) begin
                  // Unselected lanes read back as zero
                  rsp_rdata <= pin_s3_q & lane_mask(lanes_q);
                  rsp_valid <= 1'b1;
                  sram_select_low_active_n <= 1'b1;
                  sram_select_high_active <= 1'b0;
                  output_enable_n <= 1'b1;
                  upper_byte_select_n <= 1'b1;
                  lower_byte_select_n <= 1'b1;
                  cnt_q <= OHZ_CYC;
                  state_q <= ST_TURN;
               end
            end
            ST_TURN: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= dec_cnt(cnt_q);
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // asrc_host
`default_nettype wire

// ==== verification/asrc_host_properties.sv ====
// Purpose: host pin checks
// Assumes: one clock
// Notes: bound to asrc_host
`timescale 1ns/10ps
`default_nettype none
module asrc_host_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic sram_select_low_active_n,
   input wire logic sram_select_high_active,
   input wire logic sram_data_oe,
   input wire logic sram_width_select,
   input wire logic upper_byte_select_n,
   input wire logic lower_byte_select_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Strobe and select low together
   sequence s_pulse;
      (!write_strobe_n && !sram_select_low_active_n)[*3];
   endsequence
   a_pulse_len: assert property ($fell(write_strobe_n) |-> s_pulse)
      else $error("short pulse");
   a_lane_set: assert property (!write_strobe_n |->
      !(upper_byte_select_n && lower_byte_select_n)) else $error("no lane");
   a_lane_hold: assert property (!write_strobe_n |=>
      write_strobe_n || $stable({upper_byte_select_n, lower_byte_select_n}))
      else $error("lane moved");
   a_width_hi: assert property (sram_width_select)
      else $error("width low");
   a_no_fight: assert property (sram_data_oe |->
      output_enable_n && !$past(write_strobe_n)) else $error("bus fight");
   // Write data waits at least two cycles past the strobe fall
   a_data_late: assert property ($rose(sram_data_oe) |->
      !$past(write_strobe_n, 2)) else $error("data too early");
   // Select opens with the write strobe
   a_sel_with_we: assert property ($fell(write_strobe_n) |->
      $fell(sram_select_low_active_n)) else $error("select not with strobe");
   // Select is closed by the time the strobe rises
   a_desel_first: assert property ($rose(write_strobe_n) |->
      sram_select_low_active_n) else $error("select open at strobe rise");
   // Output enable stays off through a write
   a_oe_write: assert property (!write_strobe_n |->
      output_enable_n) else $error("output enable in write");
   // Reads only with both chip selects active
   a_read_sel: assert property (!output_enable_n |->
      !sram_select_low_active_n && sram_select_high_active)
      else $error("read without select");
endmodule // asrc_host_properties
bind asrc_host asrc_host_properties u_props (.clk, .reset_n, .write_strobe_n,
   .output_enable_n, .sram_select_low_active_n, .sram_select_high_active,
   .sram_data_oe, .sram_width_select, .upper_byte_select_n,
   .lower_byte_select_n);
`default_nettype wire

// ==== verification/asrc_sram_model.sv ====
// Purpose: behavioural async SRAM
// Assumes: 256 words mirror the space
// Notes: idle data lines toggle
`timescale 1ns/10ps
`default_nettype none
module asrc_sram_model (
   input wire logic clk,
   input wire logic cs_n,
   input wire logic cs_h,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic hi_n,
   input wire logic lo_n,
   input wire logic wsel,
   input wire logic [17:0] adr,
   input wire logic [15:0] din,
   output logic [15:0] dq
);
   logic [15:0] mem [0:255];
   logic [15:0] last_q = 16'h0000;
   wire sel = !cs_n && cs_h;
   wire wr = sel && !we_n;
   wire rd = sel && !oe_n && we_n;
   wire [1:0] ln = wsel ? ~{hi_n, lo_n} : 2'h3;
   always @(negedge wr) begin
      if (ln[1]) mem[adr[7:0]][15:8] = din[15:8];
      if (ln[0]) mem[adr[7:0]][7:0] = din[7:0];
   end
   assign dq = {rd && ln[1] ? mem[adr[7:0]][15:8] : ~last_q[15:8],
      rd && ln[0] ? mem[adr[7:0]][7:0] : ~last_q[7:0]};
   always @(posedge clk) last_q <= dq;
endmodule // asrc_sram_model
`default_nettype wire

// ==== verification/async_sram_rw_port_tb.sv ====
// Purpose: bench for asrc_host
// Assumes: 20 ns clock
// Notes: model on the pins
`timescale 1ns/10ps
`default_nettype none
module async_sram_rw_port_tb;
   logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0;
   logic [17:0] req_addr = 0;
   logic [15:0] req_wdata = 0;
   logic [1:0] req_lanes = 0;
   wire req_ready, rsp_valid, sram_select_low_active_n, sram_select_high_active;
   wire write_strobe_n, output_enable_n, upper_byte_select_n, sram_data_oe;
   wire lower_byte_select_n, sram_width_select;
   wire [15:0] rsp_rdata, sram_data_in, sram_data_out;
   wire [17:0] sram_addr;
   int errors = 0, checked = 0, cyc = 0;
   initial forever #10 clk = ~clk;
   asrc_host #(.AW(18), .DW(16)) uut (.clk, .reset_n, .req_valid, .req_ready,
      .req_write, .req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_rdata,
      .sram_addr, .sram_select_low_active_n, .sram_select_high_active,
      .write_strobe_n, .output_enable_n, .upper_byte_select_n,
      .lower_byte_select_n, .sram_width_select, .sram_data_in, .sram_data_out,
      .sram_data_oe);
   asrc_sram_model partner (.clk, .adr(sram_addr),
      .cs_n(sram_select_low_active_n), .cs_h(sram_select_high_active),
      .we_n(write_strobe_n), .oe_n(output_enable_n), .hi_n(upper_byte_select_n),
      .lo_n(lower_byte_select_n), .wsel(sram_width_select), .dq(sram_data_in),
      .din(sram_data_oe ? sram_data_out : ~sram_data_in));
   task tally_and_finish;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmp(input logic [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t %h %h", $time, got, exp);
      end
   endtask
   // One request, held until taken
   task op(input logic w, input logic [17:0] a, input logic [15:0] d,
      input logic [1:0] l);
      @(posedge clk) #1;
      {req_write, req_addr, req_wdata, req_lanes} = {w, a, d, l};
      req_valid = 1;
      while (req_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1 req_valid = 0;
   endtask
   task rd(input logic [17:0] a, input logic [1:0] l, input logic [15:0] m, e);
      op(0, a, 16'h0000, l);
      while (rsp_valid !== 1'b1) @(posedge clk) #1;
      cmp(rsp_rdata & m, e);
   endtask
   // Word, then each byte lane alone
   task t_lanes;
      op(1, 18'h0_0005, 16'h1234, 2'h3);
      rd(18'h0_0005, 2'h3, 16'hffff, 16'h1234);
      op(1, 18'h0_0005, 16'habcd, 2'h1);
      op(1, 18'h0_0005, 16'hee00, 2'h2);
      rd(18'h0_0005, 2'h3, 16'hffff, 16'heecd);
      rd(18'h0_0005, 2'h2, 16'hff00, 16'hee00);
   endtask
   // Empty mask write; only the low byte lane is read back and checked
   task t_empty;
      op(1, 18'h0_0009, 16'h0f0f, 2'h0);
      rd(18'h0_0009, 2'h1, 16'h00ff, 16'h000f);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 reset_n = 1;
      t_lanes;
      t_empty;
      tally_and_finish;
   end
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         tally_and_finish;
      end
   end
endmodule // async_sram_rw_port_tb
`default_nettype wire
